// ==== cmt_pkg.sv ====
`default_nettype none
package cmt_pkg;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_COUNT   = 8'h04;
  localparam logic [7:0]  ADDR_CMPA    = 8'h08;
  localparam logic [7:0]  ADDR_CMPB    = 8'h0c;
  localparam logic [7:0]  ADDR_CAPT    = 8'h10;
  localparam logic [7:0]  ADDR_FLAGS   = 8'h14;
  localparam logic [7:0]  ADDR_PORT    = 8'h18;

  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_ACTA_LSB  = 4;
  localparam int          CTRL_ACTB_LSB  = 6;
  localparam int          CTRL_FORCEA    = 8;
  localparam int          CTRL_FORCEB    = 9;
  localparam int          FLAG_OVF       = 0;
  localparam int          FLAG_CMPA      = 1;
  localparam int          FLAG_CMPB      = 2;
  localparam int          FLAG_CAPT      = 3;
  localparam int          PORT_DIR_LSB   = 0;
  localparam int          PORT_VAL_LSB   = 2;
  localparam int          PORT_LATCH_LSB = 4;

  localparam logic [3:0]  MODE_NORMAL  = 4'h0;
  localparam logic [3:0]  MODE_CTC_A   = 4'h4;
  localparam logic [3:0]  MODE_CTC_CAP = 4'hc;

  localparam logic [1:0]  ACT_NONE     = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
  localparam logic [1:0]  ACT_CLEAR    = 2'h2;
  localparam logic [1:0]  ACT_SET      = 2'h3;

  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// ==== cmt_chan_if.sv ====
`default_nettype none
interface cmt_chan_if;
  logic       match;
  logic       force_cmp;
  logic       pwm;
  logic [1:0] action;
  logic       port_val;
  logic       dir;
  logic       latch;
  logic       pin;
  logic       oe;
  modport ctrl (output match, force_cmp, pwm, action, port_val, dir,
                input  latch, pin, oe);
  modport chan (input  match, force_cmp, pwm, action, port_val, dir,
                output latch, pin, oe);
endinterface
`default_nettype wire

// ==== cmt_chan.sv ====
`default_nettype none
module cmt_chan (
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  cmt_chan_if.chan   ch
);
  logic next_latch;
  logic next_pin;
  logic next_oe;
  logic act;

  always_comb begin
    act = ch.match || (ch.force_cmp && !ch.pwm);
    next_latch = ch.latch;
    if (act) begin
      if (!ch.pwm) begin
        case (ch.action)
          cmt_pkg::ACT_TOGGLE: next_latch = !ch.latch;
          cmt_pkg::ACT_CLEAR:  next_latch = 1'b0;
          cmt_pkg::ACT_SET:    next_latch = 1'b1;
          default:             next_latch = ch.latch;
        endcase
      end else begin
        // Polarity only; no TOP-side edge, the counter never clears at top in PWM modes
        case (ch.action)
          cmt_pkg::ACT_TOGGLE: next_latch = !ch.latch;
          cmt_pkg::ACT_CLEAR:  next_latch = 1'b1;
          cmt_pkg::ACT_SET:    next_latch = 1'b0;
          default:             next_latch = ch.latch;
        endcase
      end
    end
    // Override source, but direction stays with the port
    next_pin = (ch.action != cmt_pkg::ACT_NONE) ? next_latch : ch.port_val;
    next_oe  = ch.dir;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ch.latch <= 1'b0;
      ch.pin   <= 1'b0;
      ch.oe    <= 1'b0;
    end else begin
      ch.latch <= next_latch;
      ch.pin   <= next_pin;
      ch.oe    <= next_oe;
    end
  end
endmodule
`default_nettype wire

// ==== cmt_timer.sv ====
// Operation
// - Action bits pick latch state at match
// - Reset clears the waveform latch
// - Nonzero action overrides port output value
// - Pin direction still follows direction bit
// - Action bits never touch capture logic
// - Action zero leaves latch unchanged
// - New action acts from next match
// - Force strobe applies action immediately, non-PWM
// - Counting depends on mode select only
// - Set/clear/toggle or PWM polarity select
// - Mode 0 increments and wraps only
// - Overflow flag set when count wraps
// - Overflow flag only set; service clears
// - Counter writable any time in Normal
// - CLEAR_ON_MATCH_MODE clears at compare A or capture
// - Force sets no flag, keeps counter
// - Match sets channel flag at tick
// - CLEAR_ON_MATCH_MODE top sets A or capture flag
// - Counter write blocks next tick match
`default_nettype none
module cmt_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_tick,
  input  wire logic [3:0]  i_flag_serviced,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       o_flags,
  output logic             o_pin_a,
  output logic             o_pin_a_oe,
  output logic             o_pin_b,
  output logic             o_pin_b_oe
);
  cmt_chan_if cha ();
  cmt_chan_if chb ();

  logic [7:0]  aw_addr;
  logic        aw_have;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_have;
  logic [3:0]  mode;
  logic [1:0]  act_a;
  logic [1:0]  act_b;
  logic [15:0] count;
  logic [15:0] cmpa;
  logic [15:0] cmpb;
  logic [15:0] capt;
  logic [1:0]  dir;
  logic [1:0]  port_val;
  logic        block;
  logic        force_a;
  logic        force_b;

  logic [7:0]  next_aw_addr;
  logic        next_aw_have;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_w_have;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [3:0]  next_mode;
  logic [1:0]  next_act_a;
  logic [1:0]  next_act_b;
  logic [15:0] next_count;
  logic [15:0] next_cmpa;
  logic [15:0] next_cmpb;
  logic [15:0] next_capt;
  logic [1:0]  next_dir;
  logic [1:0]  next_port_val;
  logic        next_block;
  logic        next_force_a;
  logic        next_force_b;
  logic [3:0]  next_flags;

  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic        hit;
  logic        ctc_a;
  logic        ctc_cap;
  logic        pwm;
  logic [15:0] top;
  logic        live;
  logic        match_a;
  logic        match_b;
  logic        top_hit;
  logic        cnt_wr;
  logic [3:0]  set_flags;
  logic [31:0] rword;
  logic        rhit;

  always_comb begin
    ctc_a   = (mode == cmt_pkg::MODE_CTC_A);
    ctc_cap = (mode == cmt_pkg::MODE_CTC_CAP);
    pwm     = !(mode == cmt_pkg::MODE_NORMAL || ctc_a || ctc_cap);
    top     = ctc_a ? cmpa : capt;
    // Comparator is live on a tick unless a counter write just landed
    live    = i_tick && !block;
    match_a = live && (count == cmpa);
    match_b = live && (count == cmpb);
    top_hit = live && (ctc_a || ctc_cap) && (count == top);
  end

  always_comb begin
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    do_write = aw_have && w_have && !s_axi_bvalid;
    next_aw_addr = aw_addr;
    next_aw_have = aw_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_have  = w_have;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr[7:0];
      next_aw_have = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_have = 1'b1;
    end
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
    end
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    hit = 1'b1;
    case (aw_addr)
      cmt_pkg::ADDR_CTRL, cmt_pkg::ADDR_COUNT, cmt_pkg::ADDR_CMPA, cmt_pkg::ADDR_CMPB,
      cmt_pkg::ADDR_CAPT, cmt_pkg::ADDR_FLAGS, cmt_pkg::ADDR_PORT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = hit ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
  end

  always_comb begin
    next_mode     = mode;
    next_act_a    = act_a;
    next_act_b    = act_b;
    next_cmpa     = cmpa;
    next_cmpb     = cmpb;
    next_capt     = capt;
    next_dir      = dir;
    next_port_val = port_val;
    next_force_a  = 1'b0;
    next_force_b  = 1'b0;
    cnt_wr        = 1'b0;
    wval          = RST_WORD_f(aw_addr);
    wval          = (wval & ~wmask) | (w_data & wmask);
    if (do_write) begin
      case (aw_addr)
        cmt_pkg::ADDR_CTRL: begin
          // Action change takes hold at the next match, no replay
          next_mode    = wval[cmt_pkg::CTRL_MODE_LSB +: 4];
          next_act_a   = wval[cmt_pkg::CTRL_ACTA_LSB +: 2];
          next_act_b   = wval[cmt_pkg::CTRL_ACTB_LSB +: 2];
          next_force_a = wval[cmt_pkg::CTRL_FORCEA] && w_strb[1];
          next_force_b = wval[cmt_pkg::CTRL_FORCEB] && w_strb[1];
        end
        cmt_pkg::ADDR_COUNT: cnt_wr = 1'b1;
        cmt_pkg::ADDR_CMPA:  next_cmpa = wval[15:0];
        cmt_pkg::ADDR_CMPB:  next_cmpb = wval[15:0];
        cmt_pkg::ADDR_CAPT:  next_capt = wval[15:0];
        cmt_pkg::ADDR_PORT: begin
          next_dir      = wval[cmt_pkg::PORT_DIR_LSB +: 2];
          next_port_val = wval[cmt_pkg::PORT_VAL_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  // Read-back value used to merge partial byte writes
  function automatic logic [31:0] RST_WORD_f(input logic [7:0] a);
    logic [31:0] v;
    v = cmt_pkg::RST_WORD;
    case (a)
      cmt_pkg::ADDR_CTRL:
        v = {24'h00_0000, act_b, act_a, mode};
      cmt_pkg::ADDR_COUNT: v = {16'h0000, count};
      cmt_pkg::ADDR_CMPA:  v = {16'h0000, cmpa};
      cmt_pkg::ADDR_CMPB:  v = {16'h0000, cmpb};
      cmt_pkg::ADDR_CAPT:  v = {16'h0000, capt};
      cmt_pkg::ADDR_FLAGS: v = {28'h000_0000, o_flags};
      cmt_pkg::ADDR_PORT:
        v = {26'h000_0000, chb.latch, cha.latch, port_val, dir};
      default: v = cmt_pkg::RST_WORD;
    endcase
    return v;
  endfunction

  always_comb begin
    next_count = count;
    if (cnt_wr) begin
      next_count = wval[15:0];
    end else if (i_tick) begin
      if (top_hit) begin
        next_count = cmt_pkg::COUNT_ZERO;
      end else begin
        next_count = count + 16'h0001;
      end
    end
    // Blocks the comparator for exactly one tick, even when stopped
    next_block = cnt_wr ? 1'b1 : (i_tick ? 1'b0 : block);
    set_flags = 4'h0;
    set_flags[cmt_pkg::FLAG_OVF]  = i_tick && !cnt_wr && !top_hit
                                    && (count == cmt_pkg::COUNT_MAX);
    set_flags[cmt_pkg::FLAG_CMPA] = match_a;
    set_flags[cmt_pkg::FLAG_CMPB] = match_b;
    set_flags[cmt_pkg::FLAG_CAPT] = top_hit && ctc_cap;
    next_flags = o_flags & ~i_flag_serviced;
    if (do_write && aw_addr == cmt_pkg::ADDR_FLAGS && w_strb[0]) begin
      next_flags = next_flags & ~w_data[3:0];
    end
    // Hardware set beats a same-cycle clear
    next_flags = next_flags | set_flags;
  end

  always_comb begin
    rhit = 1'b1;
    rword = RST_WORD_f(s_axi_araddr[7:0]);
    case (s_axi_araddr[7:0])
      cmt_pkg::ADDR_CTRL, cmt_pkg::ADDR_COUNT, cmt_pkg::ADDR_CMPA, cmt_pkg::ADDR_CMPB,
      cmt_pkg::ADDR_CAPT, cmt_pkg::ADDR_FLAGS, cmt_pkg::ADDR_PORT: rhit = 1'b1;
      default: rhit = 1'b0;
    endcase
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rword;
      next_rresp  = rhit ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  assign cha.match     = match_a;
  assign cha.force_cmp = force_a;
  assign cha.pwm       = pwm;
  assign cha.action    = act_a;
  assign cha.port_val  = port_val[0];
  assign cha.dir       = dir[0];
  assign chb.match     = match_b;
  assign chb.force_cmp = force_b;
  assign chb.pwm       = pwm;
  assign chb.action    = act_b;
  assign chb.port_val  = port_val[1];
  assign chb.dir       = dir[1];
  assign o_pin_a       = cha.pin;
  assign o_pin_a_oe    = cha.oe;
  assign o_pin_b       = chb.pin;
  assign o_pin_b_oe    = chb.oe;

  cmt_chan u_chan_a (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .ch     (cha.chan)
  );

  cmt_chan u_chan_b (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .ch     (chb.chan)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_addr       <= 8'h00;
      aw_have       <= 1'b0;
      w_data        <= cmt_pkg::RST_WORD;
      w_strb        <= 4'h0;
      w_have        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cmt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= cmt_pkg::RST_WORD;
      s_axi_rresp   <= cmt_pkg::RESP_OKAY;
      mode          <= cmt_pkg::MODE_NORMAL;
      act_a         <= cmt_pkg::ACT_NONE;
      act_b         <= cmt_pkg::ACT_NONE;
      count         <= cmt_pkg::COUNT_ZERO;
      cmpa          <= cmt_pkg::COUNT_ZERO;
      cmpb          <= cmt_pkg::COUNT_ZERO;
      capt          <= cmt_pkg::COUNT_ZERO;
      dir           <= 2'h0;
      port_val      <= 2'h0;
      block         <= 1'b0;
      force_a       <= 1'b0;
      force_b       <= 1'b0;
      o_flags       <= 4'h0;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_have       <= next_aw_have;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_have        <= next_w_have;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      mode          <= next_mode;
      act_a         <= next_act_a;
      act_b         <= next_act_b;
      count         <= next_count;
      cmpa          <= next_cmpa;
      cmpb          <= next_cmpb;
      capt          <= next_capt;
      dir           <= next_dir;
      port_val      <= next_port_val;
      block         <= next_block;
      force_a       <= next_force_a;
      force_b       <= next_force_b;
      o_flags       <= next_flags;
    end
  end
endmodule
`default_nettype wire

// ==== cmt_timer_assertions.sv ====
`default_nettype none
module cmt_chk (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_tick,
  input wire logic [3:0]  i_flag_serviced,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  o_flags,
  input wire logic        o_pin_a,
  input wire logic        o_pin_a_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_RST_CLEAR: assert property ($rose(i_rstn) |-> !o_pin_a && o_flags == 4'h0)
    else $error("pin or flags not clear after reset");
  AST_FLAG_ON_TICK: assert property (|(o_flags & ~$past(o_flags)) |-> $past(i_tick))
    else $error("flag set without a timer tick");
  AST_OVF_CLEAR: assert property ($fell(o_flags[0]) |-> $past(i_flag_serviced[0]) || $rose(s_axi_bvalid))
    else $error("overflow flag cleared without service or write");
  AST_OE_ON_WRITE: assert property ($changed(o_pin_a_oe) |-> $past(s_axi_bvalid))
    else $error("pin enable moved without a register write");
  AST_WR_ANSWER: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_B_BLOCKS_AW: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted during response");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule
bind cmt_timer cmt_chk u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_tick(i_tick), .i_flag_serviced(i_flag_serviced),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .o_flags(o_flags),
  .o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe));
`default_nettype wire

// ==== cmt_pin_model.sv ====
`default_nettype none
module cmt_pin_model (
  input  wire logic i_pin,
  input  wire logic i_oe,
  output wire logic o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-up holds the line while the pin is an input
  assign o_pad = i_oe ? i_pin : 1'b1;
endmodule
`default_nettype wire

// ==== tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk  = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_tick = 1'b0;
  logic [3:0]  fsv    = 4'h0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata  = '0;
  logic [31:0] araddr = '0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  wire logic        awready, wready, bvalid, arready, rvalid, pin_a, oe_a, pad_a;
  wire logic        pin_b, oe_b;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  flags;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  int          m_cnt, m_mode, m_act, m_cmpa, m_cmpb, m_capt, m_flags, m_latch, m_blk, m_port;
  int          acts[4] = '{3, 0, 2, 1};
  logic [31:0] v;

  cmt_timer dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_tick(i_tick), .i_flag_serviced(fsv),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .o_flags(flags), .o_pin_a(pin_a), .o_pin_a_oe(oe_a),
    .o_pin_b(pin_b), .o_pin_b_oe(oe_b));
  cmt_pin_model u_pin (.i_pin(pin_a), .i_oe(oe_a), .o_pad(pad_a));

  always #5 i_clk = ~i_clk;

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a <= 8'h18 && a[1:0] == 2'h0) ? cmt_pkg::RESP_OKAY : cmt_pkg::RESP_SLVERR;
  endfunction

  function automatic int act_fn(input int a, input int l);
    case (a)
      1: return l ^ 1;
      2: return 0;
      3: return 1;
      default: return l;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic       aw_ok;
    logic       w_ok;
    logic       b_ok;
    logic [1:0] r_sp;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      // Handshakes read settled before the edge, not racing it
      @(negedge i_clk);
      aw_ok = awready;
      w_ok  = wready;
      b_ok  = bvalid;
      r_sp  = bresp;
      @(posedge i_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
    chk("bresp", resp_of(a), r_sp);
    bready <= 1'b0;
    // One idle edge so the next call never re-drives bready in this step
    @(posedge i_clk);
    case (a)
      cmt_pkg::ADDR_CTRL: begin
        m_mode = d[3:0];
        m_act = d[5:4];
        if (d[8] && d[3:0] inside {4'h0, 4'h4, 4'hc}) m_latch = act_fn(m_act, m_latch);
      end
      cmt_pkg::ADDR_COUNT: begin
        m_cnt = d[15:0];
        m_blk = 1;
      end
      cmt_pkg::ADDR_CMPA: m_cmpa = d[15:0];
      cmt_pkg::ADDR_CMPB: m_cmpb = d[15:0];
      cmt_pkg::ADDR_CAPT: m_capt = d[15:0];
      cmt_pkg::ADDR_FLAGS: m_flags &= ~d[3:0];
      cmt_pkg::ADDR_PORT: m_port = d[3:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic       ar_ok;
    logic       r_ok;
    logic [1:0] r_sp;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ar_ok = arready;
      r_ok  = rvalid;
      d     = rdata;
      r_sp  = rresp;
      @(posedge i_clk);
      if (ar_ok) arvalid <= 1'b0;
    end while (!r_ok);
    chk("rresp", resp_of(a), r_sp);
    rready <= 1'b0;
    @(posedge i_clk);
  endtask

  // Reference counter step for one enabled timer tick
  function automatic void step();
    int hit;
    int a;
    // PWM modes swap the meaning of clear and set
    a = (m_mode inside {0, 4, 12} || m_act < 2) ? m_act : m_act ^ 1;
    // A blocked tick also suppresses the clear at top
    hit = !m_blk && ((m_mode == 4 && m_cnt == m_cmpa) || (m_mode == 12 && m_cnt == m_capt));
    if (!m_blk && m_cnt == m_cmpa) begin
      m_flags |= 2;
      m_latch = act_fn(a, m_latch);
    end
    if (!m_blk && m_cnt == m_cmpb) m_flags |= 4;
    if (hit && m_mode == 12) m_flags |= 8;
    if (!hit && m_cnt == 'hffff) m_flags |= 1;
    m_cnt = hit ? 0 : (m_cnt + 1) & 'hffff;
    m_blk = 0;
  endfunction

  task automatic tk(input int n);
    repeat (n) begin
      i_tick <= 1'b1;
      step();
      @(posedge i_clk);
      i_tick <= 1'b0;
      repeat (1 + $urandom % 3) @(posedge i_clk);
    end
  endtask

  task automatic chk_state();
    logic [31:0] d;
    rd(cmt_pkg::ADDR_COUNT, d);
    chk("count", m_cnt, d);
    rd(cmt_pkg::ADDR_FLAGS, d);
    chk("flags", m_flags, d);
    rd(cmt_pkg::ADDR_PORT, d);
    chk("port", m_port, d[3:0]);
    chk("latch", m_latch, d[4]);
    chk("latch_b", 0, d[5]);
    // Outputs looked at mid-cycle, away from the edge that launches them
    @(negedge i_clk);
    chk("flag_out", m_flags, flags);
    chk("oe", m_port[0], oe_a);
    chk("pad", !m_port[0] ? 1 : (m_act != 0) ? m_latch : m_port[2], pad_a);
    chk("pin_b", m_port[3], pin_b);
    chk("oe_b", m_port[1], oe_b);
    @(posedge i_clk);
  endtask

  initial begin
    void'($urandom(32'h582f2259));
    {m_cnt, m_mode, m_act, m_cmpa, m_cmpb, m_capt, m_flags, m_latch, m_blk, m_port} = '0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    chk_state();
    wr(8'h40, 32'h5a);
    rd(8'h40, v);
    chk("rdata", 32'h0, v);
    wr(cmt_pkg::ADDR_PORT, 32'h1);
    wr(cmt_pkg::ADDR_CMPA, 32'h1234);
    foreach (acts[i]) begin
      wr(cmt_pkg::ADDR_CTRL, 32'h100 | (acts[i] << 4));
      repeat (3) @(posedge i_clk);
      chk_state();
    end
    wr(cmt_pkg::ADDR_PORT, 32'hc);
    chk_state();
    wr(cmt_pkg::ADDR_PORT, 32'h3);
    wr(cmt_pkg::ADDR_CTRL, 32'h0);
    wr(cmt_pkg::ADDR_CMPA, 32'hfffe);
    wr(cmt_pkg::ADDR_COUNT, 32'hfffd);
    tk(4);
    chk_state();
    fsv <= 4'h1;
    @(posedge i_clk);
    fsv <= 4'h0;
    m_flags &= ~1;
    @(posedge i_clk);
    chk_state();
    wr(cmt_pkg::ADDR_FLAGS, 32'hf);
    wr(cmt_pkg::ADDR_CMPA, 32'h3);
    wr(cmt_pkg::ADDR_CAPT, 32'h5);
    foreach (acts[i]) begin
      if (i < 2) begin
        wr(cmt_pkg::ADDR_COUNT, 32'h0);
        wr(cmt_pkg::ADDR_CTRL, (i ? 32'hc : 32'h4) | 32'h10);
        tk(9);
        chk_state();
        wr(cmt_pkg::ADDR_CTRL, (i ? 32'hc : 32'h4) | 32'h30);
        tk(5);
        chk_state();
      end
    end
    wr(cmt_pkg::ADDR_CTRL, 32'h0);
    repeat (3) begin
      v = $urandom & 32'hffff;
      wr(cmt_pkg::ADDR_CMPA, v);
      wr(cmt_pkg::ADDR_COUNT, v);
      tk(1);
      chk_state();
    end
    // PWM mode: force ignored, set drives the latch low on a match
    wr(cmt_pkg::ADDR_CTRL, 32'h125);
    wr(cmt_pkg::ADDR_CMPA, 32'h10);
    wr(cmt_pkg::ADDR_COUNT, 32'hf);
    wr(cmt_pkg::ADDR_CTRL, 32'h35);
    tk(2);
    chk_state();
    end_of_test();
  end
endmodule
`default_nettype wire
